// [common/pll_base_clock_control_map.svh]
// register offsets, field positions, reset values and timing counts
`ifndef PLL_BASE_CLOCK_CONTROL_MAP_SVH
`define PLL_BASE_CLOCK_CONTROL_MAP_SVH

// register byte addresses
`define LOOP_CONTROL_ADDR      8'h00
`define BANDWIDTH_CONTROL_ADDR 8'h01
`define FEEDBACK_MULT_HI_ADDR  8'h02
`define FEEDBACK_MULT_LO_ADDR  8'h03
`define VCO_CENTRE_RANGE_ADDR  8'h04
`define REF_DIVIDER_SEL_ADDR   8'h05

// loop_control field positions
`define LC_IRQ_EN_BIT          7
`define LC_FLAG_BIT            6
`define LC_POWER_ON_BIT        5
`define LC_CLK_SEL_BIT         4
`define LC_PRESCALE_HI         3
`define LC_PRESCALE_LO         2
`define LC_VCO_EXP_HI          1
`define LC_VCO_EXP_LO          0

// bandwidth_control field positions
`define BW_SELF_TUNE_BIT       7
`define BW_SETTLED_BIT         6
`define BW_TRACK_BIT           5

// reset values
`define POWER_ON_RESET         1'h1
`define FEEDBACK_MULT_RESET    12'h040
`define CENTRE_RANGE_RESET     8'h40
`define REF_DIVISION_RESET     4'h1

// source clock edges waited on each side during a changeover
`define SWITCH_EDGE_COUNT      3

`endif

// [common/pll_base_clock_control_pkg.sv]
// types shared by the clock control block
package pll_base_clock_control_pkg;

	// base clock selector changeover states
	typedef enum logic [0:0] {
		SEL_RUN,
		SEL_SWITCH
	} sel_state_t;

	// base clock source
	typedef enum logic [0:0] {
		SRC_OSC,
		SRC_VCO
	} clk_src_t;

endpackage

// [design/pll_base_clock_control.sv]
// register file, protections, lock flag and base clock selector of the pll
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "pll_base_clock_control_map.svh"

// Behaviour
// RULE1 - divider fields writable only while loop off
// RULE2 - software loads P, E, N, L, R binary
// RULE3 - zero reference divider or multiplier means one
// RULE4 - zero range disables loop, refuses vco select
// RULE5 - zero range forces oscillator back as source
// RULE6 - changeover waits three edges, output held still
// RULE7 - selected clock halved to 50 percent duty
// RULE8 - vco select refused while loop off
// RULE9 - loop off refused while vco selected
// RULE10 - each protection judged against current state
// RULE11 - reference clock is buffered oscillator clock
// RULE12 - single interrupt output from lock flag
// RULE13 - irq enable blocked, reads zero in manual
// RULE14 - lock toggle sets flag, reset clears
// RULE15 - interrupt when flag and enable both set
// RULE16 - flag reads zero in manual mode
// RULE17 - loop_control read clears the flag
// RULE18 - power on enables loop, reset sets it
// RULE19 - select picks vco or oscillator, reset clears
// RULE20 - prescale encodes P directly, reset zero
// RULE21 - self tuning select chooses auto, reset clears
// RULE22 - settled flag in auto, zero in manual
// RULE23 - interrupt level until read or disabled
// RULE24 - lock synchronised then compared with previous
module pll_base_clock_control #(
	parameter int EDGE_WAIT = `SWITCH_EDGE_COUNT // edges per side to wait
) (
	input  wire logic       sys_clk,             // bus clock, 250 MHz
	input  wire logic       reset_n,             // async reset, active low
	input  wire logic [7:0] addr,                // register byte address
	input  wire logic [7:0] wr_data,             // write data
	input  wire logic       wr_en,               // write strobe
	input  wire logic       rd_en,               // read strobe
	output logic      [7:0] rd_data,             // read data, next cycle
	input  wire logic       oscillator_clock,    // oscillator clock pin
	input  wire logic       divided_vco_clock,   // prescaled vco clock pin
	input  wire logic       lock_detect,         // lock indicator, loop side
	input  wire logic       track_detect,        // filter tracking, loop side
	output logic            loop_reference_clock, // buffered oscillator
	output logic            base_clock_out,      // halved selected clock
	output logic            clockgen_irq,        // interrupt level
	output logic            loop_enable,         // loop and vco enabled
	output logic      [1:0] prescale_exp,        // prescale exponent P
	output logic      [1:0] vco_range_exponent,  // vco range exponent E
	output logic     [11:0] feedback_multiplier, // effective N
	output logic      [7:0] vco_centre_multiplier, // range multiplier L
	output logic      [3:0] reference_division,  // effective R
	output logic            filter_track_mode,   // filter in tracking
	output logic            self_tune_mode       // automatic bandwidth
);

	// refuse edge counts the two-bit counters cannot hold
	if (EDGE_WAIT < 1 || EDGE_WAIT > 3) begin : g_bad
		$error("EDGE_WAIT must lie in 1..3");
	end

	localparam logic [1:0] EDGE_WAIT_C = EDGE_WAIT[1:0]; // counter target

	// register bits
	logic        irq_en_r;          // lock_irq_enable
	logic        flag_r;            // lock_change_flag
	logic        power_on_r;        // loop_power_on
	logic        clk_sel_r;         // base_clock_select
	logic [1:0]  prescale_r;        // prescale exponent
	logic [1:0]  vco_exp_r;         // vco range exponent
	logic        self_tune_r;       // self_tuning_select
	logic        track_manual_r;    // manually written track bit
	logic [11:0] mult_r;            // feedback multiplier as written
	logic [7:0]  range_r;           // vco centre multiplier
	logic [3:0]  ref_div_r;         // reference division as written
	logic [7:0]  rd_data_r;         // registered read data

	// synchronisers and edge history
	logic        lock_s1_r;         // lock first stage
	logic        lock_s2_r;         // lock second stage
	logic        lock_prev_r;       // lock previous sample
	logic        track_s1_r;        // tracking first stage
	logic        track_s2_r;        // tracking second stage
	logic        osc_s1_r;          // oscillator first stage
	logic        osc_s2_r;          // oscillator second stage
	logic        osc_prev_r;        // oscillator previous sample
	logic        vco_s1_r;          // vco first stage
	logic        vco_s2_r;          // vco second stage
	logic        vco_prev_r;        // vco previous sample

	// selector state
	pll_base_clock_control_pkg::sel_state_t sel_state_r; // changeover
	pll_base_clock_control_pkg::clk_src_t   active_src_r; // driving source
	logic [1:0]  osc_cnt_r;         // oscillator edges seen
	logic [1:0]  vco_cnt_r;         // vco edges seen
	logic        base_clk_r;        // halved output

	// decoded strobes and conditions
	logic        wr_lc;             // write to loop_control
	logic        wr_bw;             // write to bandwidth_control
	logic        wr_mh;             // write to feedback_mult_high
	logic        wr_ml;             // write to feedback_mult_low
	logic        wr_vr;             // write to vco_centre_range
	logic        wr_rd;             // write to reference_divider_select
	logic        rd_lc;             // read of loop_control
	logic        range_zero;        // range multiplier holds zero
	logic        lock_toggle;       // lock indicator changed
	logic        osc_rise;          // oscillator rising edge
	logic        vco_rise;          // vco rising edge
	logic        src_rise;          // rising edge of active source
	logic        vco_done;          // vco side of changeover complete
	logic        settled;           // lock as seen by software
	logic        track_auto;        // tracking as seen by software
	logic        sel_allowed;       // vco selection would be accepted
	logic [7:0]  lc_view;           // loop_control read view
	logic [7:0]  bw_view;           // bandwidth_control read view
	logic [7:0]  rd_mux;            // selected read value

	// address decode of the strobes
	assign wr_lc = wr_en && (addr == `LOOP_CONTROL_ADDR);
	assign wr_bw = wr_en && (addr == `BANDWIDTH_CONTROL_ADDR);
	assign wr_mh = wr_en && (addr == `FEEDBACK_MULT_HI_ADDR);
	assign wr_ml = wr_en && (addr == `FEEDBACK_MULT_LO_ADDR);
	assign wr_vr = wr_en && (addr == `VCO_CENTRE_RANGE_ADDR);
	assign wr_rd = wr_en && (addr == `REF_DIVIDER_SEL_ADDR);
	assign rd_lc = rd_en && (addr == `LOOP_CONTROL_ADDR);

	assign range_zero = (range_r == 8'h00);
	assign lock_toggle = lock_s2_r ^ lock_prev_r; // RULE24
	assign settled = lock_s2_r & self_tune_r; // RULE22
	assign track_auto = self_tune_r ? track_s2_r : track_manual_r;
	// vco may be chosen only from a running loop with nonzero range
	assign sel_allowed = power_on_r && !range_zero; // RULE8 RULE4 RULE10

	// power on, judged against the current clock select
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			power_on_r <= `POWER_ON_RESET; // RULE18
		end else if (wr_lc) begin
			// clearing refused while the base clock select names the vco
			if (wr_data[`LC_POWER_ON_BIT] || !clk_sel_r) begin
				power_on_r <= wr_data[`LC_POWER_ON_BIT]; // RULE9 RULE10
			end
		end
	end

	// base clock select, refused or forced back as needed
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_sel_r <= 1'b0; // RULE19
		end else if (range_zero) begin
			clk_sel_r <= 1'b0; // RULE5 RULE4
		end else if (wr_lc) begin
			// setting needs the loop already on before this write
			if (!wr_data[`LC_CLK_SEL_BIT] || sel_allowed) begin
				clk_sel_r <= wr_data[`LC_CLK_SEL_BIT]; // RULE8 RULE10
			end
		end
	end

	// prescale and vco exponents, frozen while the loop runs
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prescale_r <= 2'h0; // RULE20
			vco_exp_r  <= 2'h0;
		end else if (wr_lc && !power_on_r) begin
			prescale_r <= wr_data[`LC_PRESCALE_HI:`LC_PRESCALE_LO]; // RULE1
			vco_exp_r  <= wr_data[`LC_VCO_EXP_HI:`LC_VCO_EXP_LO]; // RULE1
		end
	end

	// interrupt enable, writable only in automatic mode
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_en_r <= 1'b0; // RULE13
		end else if (wr_lc && self_tune_r) begin
			irq_en_r <= wr_data[`LC_IRQ_EN_BIT]; // RULE13
		end
	end

	// lock change flag: a toggle in the clearing cycle wins
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			flag_r <= 1'b0; // RULE14
		end else if (lock_toggle) begin
			flag_r <= 1'b1; // RULE14
		end else if (rd_lc) begin
			flag_r <= 1'b0; // RULE17
		end
	end

	// bandwidth mode and manual tracking bit
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			self_tune_r    <= 1'b0; // RULE21
			track_manual_r <= 1'b0;
		end else if (wr_bw) begin
			self_tune_r <= wr_data[`BW_SELF_TUNE_BIT]; // RULE21
			// in automatic mode the manual value is kept aside
			if (!self_tune_r) begin
				track_manual_r <= wr_data[`BW_TRACK_BIT];
			end
		end
	end

	// loop divider registers, frozen while the loop runs
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mult_r    <= `FEEDBACK_MULT_RESET;
			range_r   <= `CENTRE_RANGE_RESET;
			ref_div_r <= `REF_DIVISION_RESET;
		end else if (!power_on_r) begin
			if (wr_mh) begin
				mult_r[11:8] <= wr_data[3:0]; // RULE1
			end
			if (wr_ml) begin
				mult_r[7:0] <= wr_data; // RULE1
			end
			if (wr_vr) begin
				range_r <= wr_data; // RULE1
			end
			if (wr_rd) begin
				ref_div_r <= wr_data[3:0]; // RULE1
			end
		end
	end

	// read views of the status-bearing registers
	always_comb begin
		lc_view = 8'h00;
		lc_view[`LC_IRQ_EN_BIT]   = irq_en_r & self_tune_r; // RULE13
		lc_view[`LC_FLAG_BIT]     = flag_r & self_tune_r; // RULE16
		lc_view[`LC_POWER_ON_BIT] = power_on_r;
		lc_view[`LC_CLK_SEL_BIT]  = clk_sel_r;
		lc_view[`LC_PRESCALE_HI:`LC_PRESCALE_LO] = prescale_r;
		lc_view[`LC_VCO_EXP_HI:`LC_VCO_EXP_LO]   = vco_exp_r;
		bw_view = 8'h00;
		bw_view[`BW_SELF_TUNE_BIT] = self_tune_r;
		bw_view[`BW_SETTLED_BIT]   = settled; // RULE22
		bw_view[`BW_TRACK_BIT]     = track_auto;
	end

	// read multiplexer, unmapped addresses read zero
	always_comb begin
		case (addr)
			`LOOP_CONTROL_ADDR:      rd_mux = lc_view;
			`BANDWIDTH_CONTROL_ADDR: rd_mux = bw_view;
			`FEEDBACK_MULT_HI_ADDR:  rd_mux = {4'h0, mult_r[11:8]};
			`FEEDBACK_MULT_LO_ADDR:  rd_mux = mult_r[7:0];
			`VCO_CENTRE_RANGE_ADDR:  rd_mux = range_r;
			`REF_DIVIDER_SEL_ADDR:   rd_mux = {4'h0, ref_div_r};
			default:                 rd_mux = 8'h00;
		endcase
	end

	// read data stands for one cycle after the strobe
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_r <= 8'h00;
		end else if (rd_en) begin
			rd_data_r <= rd_mux;
		end else begin
			rd_data_r <= 8'h00;
		end
	end

	// loop side indicators brought into the bus domain
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			lock_s1_r   <= 1'b0;
			lock_s2_r   <= 1'b0;
			lock_prev_r <= 1'b0;
			track_s1_r  <= 1'b0;
			track_s2_r  <= 1'b0;
		end else begin
			lock_s1_r   <= lock_detect; // RULE24
			lock_s2_r   <= lock_s1_r;
			lock_prev_r <= lock_s2_r;
			track_s1_r  <= track_detect;
			track_s2_r  <= track_s1_r;
		end
	end

	// source clocks sampled for edge detection
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			osc_s1_r   <= 1'b0;
			osc_s2_r   <= 1'b0;
			osc_prev_r <= 1'b0;
			vco_s1_r   <= 1'b0;
			vco_s2_r   <= 1'b0;
			vco_prev_r <= 1'b0;
		end else begin
			osc_s1_r   <= oscillator_clock;
			osc_s2_r   <= osc_s1_r;
			osc_prev_r <= osc_s2_r;
			vco_s1_r   <= divided_vco_clock;
			vco_s2_r   <= vco_s1_r;
			vco_prev_r <= vco_s2_r;
		end
	end

	assign osc_rise = osc_s2_r & ~osc_prev_r;
	assign vco_rise = vco_s2_r & ~vco_prev_r;
	assign src_rise = (active_src_r == pll_base_clock_control_pkg::SRC_VCO)
		? vco_rise : osc_rise;
	// a stopped vco cannot be waited on once the loop is disabled
	assign vco_done = (vco_cnt_r == EDGE_WAIT_C) || !loop_enable;

	// changeover: count edges of both sources, then swap
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_state_r  <= pll_base_clock_control_pkg::SEL_RUN;
			active_src_r <= pll_base_clock_control_pkg::SRC_OSC;
			osc_cnt_r    <= 2'h0;
			vco_cnt_r    <= 2'h0;
		end else begin
			case (sel_state_r)
				pll_base_clock_control_pkg::SEL_RUN: begin
					osc_cnt_r <= 2'h0;
					vco_cnt_r <= 2'h0;
					if (clk_sel_r != active_src_r) begin
						sel_state_r <= pll_base_clock_control_pkg::SEL_SWITCH;
					end
				end
				pll_base_clock_control_pkg::SEL_SWITCH: begin
					if (osc_rise && osc_cnt_r != EDGE_WAIT_C) begin
						osc_cnt_r <= osc_cnt_r + 2'h1; // RULE6
					end
					if (vco_rise && vco_cnt_r != EDGE_WAIT_C) begin
						vco_cnt_r <= vco_cnt_r + 2'h1; // RULE6
					end
					if (osc_cnt_r == EDGE_WAIT_C && vco_done) begin
						active_src_r <= pll_base_clock_control_pkg::clk_src_t'(
							clk_sel_r); // RULE19
						sel_state_r  <= pll_base_clock_control_pkg::SEL_RUN;
					end
				end
				default: begin
					sel_state_r <= pll_base_clock_control_pkg::SEL_RUN;
				end
			endcase
		end
	end

	// halving stage, held still during a changeover
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			base_clk_r <= 1'b0;
		end else if (sel_state_r == pll_base_clock_control_pkg::SEL_RUN
			&& src_rise) begin
			base_clk_r <= ~base_clk_r; // RULE7 RULE6
		end
	end

	// outputs toward the analog loop and system
	assign loop_reference_clock  = oscillator_clock; // RULE11
	assign base_clock_out        = base_clk_r; // RULE7
	assign clockgen_irq          = flag_r & irq_en_r
		& self_tune_r; // RULE12 RULE15 RULE23
	assign loop_enable           = power_on_r & !range_zero; // RULE18 RULE4
	assign prescale_exp          = prescale_r; // RULE20
	assign vco_range_exponent    = vco_exp_r;
	assign feedback_multiplier   = (mult_r == 12'h000) ? 12'h001 : mult_r; // RULE3
	assign vco_centre_multiplier = range_r;
	assign reference_division    = (ref_div_r == 4'h0) ? 4'h1 : ref_div_r; // RULE3
	assign filter_track_mode     = track_auto;
	assign self_tune_mode        = self_tune_r;
	assign rd_data               = rd_data_r;

endmodule

// [testbench/pll_base_clock_control_assertions.sv]
// port-level checker of the clock control block
`timescale 1ns/100ps
`include "pll_base_clock_control_map.svh"
module pll_base_clock_control_checker #(
	parameter int EDGE_WAIT = `SWITCH_EDGE_COUNT // edges per side
) (
	input wire logic        sys_clk,               // bus clock
	input wire logic        reset_n,               // async reset, low
	input wire logic  [7:0] addr,                  // register address
	input wire logic        wr_en,                 // write strobe
	input wire logic        rd_en,                 // read strobe
	input wire logic        oscillator_clock,      // oscillator pin
	input wire logic        divided_vco_clock,     // vco pin
	input wire logic        lock_detect,           // lock indicator
	input wire logic        loop_reference_clock,  // reference copy
	input wire logic        base_clock_out,        // base clock
	input wire logic        clockgen_irq,          // interrupt level
	input wire logic        loop_enable,           // loop running
	input wire logic  [1:0] prescale_exp,          // exponent P
	input wire logic  [1:0] vco_range_exponent,    // exponent E
	input wire logic [11:0] feedback_multiplier,   // effective N
	input wire logic  [7:0] vco_centre_multiplier, // range L
	input wire logic  [3:0] reference_division,    // effective R
	input wire logic        self_tune_mode         // automatic mode
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	logic       lock_r;    // previous lock sample
	logic       osc_r;     // previous oscillator sample
	logic       vco_r;     // previous vco sample
	logic [3:0] quiet_r;   // cycles since lock last moved
	logic [3:0] osc_age_r; // cycles since oscillator rose
	logic [3:0] vco_age_r; // cycles since vco rose

	// sample the asynchronous inputs
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			lock_r <= 1'b0;
			osc_r <= 1'b0;
			vco_r <= 1'b0;
		end else begin
			lock_r <= lock_detect;
			osc_r <= oscillator_clock;
			vco_r <= divided_vco_clock;
		end
	end

	// saturating age counters of the input events
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			quiet_r <= 4'h0;
			osc_age_r <= 4'hF;
			vco_age_r <= 4'hF;
		end else begin
			quiet_r <= (lock_detect != lock_r) ? 4'h0 :
				((quiet_r == 4'hF) ? 4'hF : quiet_r + 4'h1);
			osc_age_r <= (oscillator_clock && !osc_r) ? 4'h0 :
				((osc_age_r == 4'hF) ? 4'hF : osc_age_r + 4'h1);
			vco_age_r <= (divided_vco_clock && !vco_r) ? 4'h0 :
				((vco_age_r == 4'hF) ? 4'hF : vco_age_r + 4'h1);
		end
	end

	property p_div_hold;
		$past(loop_enable) |-> $stable(prescale_exp) &&
			$stable(vco_range_exponent) && $stable(feedback_multiplier) &&
			$stable(vco_centre_multiplier) && $stable(reference_division);
	endproperty
	a_div_hold: assert property (p_div_hold)
		else $error("divider field moved while loop running");
	property p_zero_one;
		feedback_multiplier != 12'h000 && reference_division != 4'h0;
	endproperty
	a_zero_one: assert property (p_zero_one)
		else $error("zero divider not shown as one");
	property p_range_zero;
		vco_centre_multiplier == 8'h00 |-> !loop_enable;
	endproperty
	a_range_zero: assert property (p_range_zero)
		else $error("loop enabled with zero range");
	property p_base_src;
		$changed(base_clock_out) |-> osc_age_r <= 4'h8 || vco_age_r <= 4'h8;
	endproperty
	a_base_src: assert property (p_base_src)
		else $error("base clock moved without a source edge");
	property p_ref_buf;
		loop_reference_clock == oscillator_clock;
	endproperty
	a_ref_buf: assert property (p_ref_buf)
		else $error("reference clock differs from oscillator");
	property p_irq_auto;
		clockgen_irq |-> self_tune_mode;
	endproperty
	a_irq_auto: assert property (p_irq_auto)
		else $error("interrupt raised in manual mode");
	property p_rd_clear;
		rd_en && addr == `LOOP_CONTROL_ADDR && quiet_r > 4'h7 |=>
			!clockgen_irq [*2];
	endproperty
	a_rd_clear: assert property (p_rd_clear)
		else $error("control read did not drop the interrupt");
	property p_irq_level;
		clockgen_irq && !rd_en && !wr_en |=> clockgen_irq;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("interrupt dropped without a clearing access");
	property p_reset_vals;
		$rose(reset_n) |-> loop_enable && !self_tune_mode &&
			feedback_multiplier == `FEEDBACK_MULT_RESET &&
			vco_centre_multiplier == `CENTRE_RANGE_RESET;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("reset values wrong at release");

	c_irq_read: cover property (rd_en && addr == 8'h00 && clockgen_irq);
	c_irq_rise: cover property ($rose(clockgen_irq));
	c_loop_off: cover property ($fell(loop_enable));
endmodule

// [testbench/loop_partner_model.sv]
// model of the loop side: oscillator, divided vco and lock indicator
`timescale 1ns/100ps
module loop_partner_model #(
	parameter int OSC_HALF = 20, // oscillator half period, ns
	parameter int VCO_HALF = 12  // divided vco half period, ns
) (
	output logic      oscillator_clock,  // free running oscillator
	output logic      divided_vco_clock, // runs only with loop on
	output logic      lock_detect,       // lock level, async
	output logic      track_detect,      // tracking follows lock
	input  wire logic loop_enable,       // loop enable from block
	input  wire logic lock_req           // lock state asked by bench
);
	// oscillator never stops
	initial begin
		oscillator_clock = 1'b0;
		forever #(OSC_HALF) oscillator_clock = ~oscillator_clock;
	end

	// vco stands still at 0 while the loop is off
	initial begin
		divided_vco_clock = 1'b0;
		forever begin
			#(VCO_HALF);
			divided_vco_clock = loop_enable ? ~divided_vco_clock : 1'b0;
		end
	end

	// lock moves a few ns off the bus clock edge
	assign #3 lock_detect = lock_req;
	assign track_detect = lock_detect;
endmodule

// [testbench/testbench.sv]
// self-checking bench of the clock control block
`timescale 1ns/100ps
`include "pll_base_clock_control_map.svh"
module testbench;
	logic        sys_clk, reset_n, wr_en, rd_en, lock_req; // bench drives
	logic  [7:0] addr, wr_data, rd_data;    // register bus
	logic        oscillator_clock, divided_vco_clock; // loop clocks
	logic        lock_detect, track_detect; // loop indicators
	logic        loop_reference_clock, base_clock_out, clockgen_irq;
	logic        loop_enable, filter_track_mode, self_tune_mode;
	logic  [1:0] prescale_exp, vco_range_exponent; // exponents
	logic [11:0] feedback_multiplier;       // effective N
	logic  [7:0] vco_centre_multiplier;     // range L
	logic  [3:0] reference_division;        // effective R
	int          on, sel, pre, ve, n, lm, rr, ie, au, fl, tm, lk; // model
	int          bad_count, n_checks, seed, i, c;
	logic        b;                         // held base clock level

	pll_base_clock_control dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data(rd_data), .oscillator_clock(oscillator_clock),
		.divided_vco_clock(divided_vco_clock), .lock_detect(lock_detect),
		.track_detect(track_detect),
		.loop_reference_clock(loop_reference_clock),
		.base_clock_out(base_clock_out), .clockgen_irq(clockgen_irq),
		.loop_enable(loop_enable), .prescale_exp(prescale_exp),
		.vco_range_exponent(vco_range_exponent),
		.feedback_multiplier(feedback_multiplier),
		.vco_centre_multiplier(vco_centre_multiplier),
		.reference_division(reference_division),
		.filter_track_mode(filter_track_mode),
		.self_tune_mode(self_tune_mode));
	loop_partner_model partner (.oscillator_clock(oscillator_clock),
		.divided_vco_clock(divided_vco_clock), .lock_detect(lock_detect),
		.track_detect(track_detect), .loop_enable(loop_enable),
		.lock_req(lock_req));

	// verdict and end of run
	task wrap_up();
		if (bad_count == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// one comparison
	task ck(input string nm, input int e, input logic [15:0] g);
		n_checks++;
		if (g !== 16'(e)) begin
			bad_count++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	// bus write, then model update against the state before it
	task wr(input logic [7:0] a, input logic [7:0] d);
		int ns;
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		case (a)
			8'h00: begin
				if (au) ie = d[7];
				if (!on) pre = d[3:2];
				if (!on) ve = d[1:0];
				ns = d[4] ? ((on && lm != 0) ? 1 : sel) : 0;
				on = (sel && !d[5]) ? 1 : d[5];
				sel = ns;
			end
			8'h01: begin
				if (!au) tm = d[5];
				au = d[7];
			end
			8'h02: if (!on) n = (n & 'hFF) | (int'(d[3:0]) << 8);
			8'h03: if (!on) n = (n & 'hF00) | d;
			8'h04: if (!on) lm = d;
			8'h05: if (!on) rr = d[3:0];
			default: ;
		endcase
	endtask

	// read with expected view; a control read clears the flag
	task rd(input logic [7:0] a);
		int e;
		e = (a == 8'h00) ? ((au && ie ? 128 : 0) | (au && fl ? 64 : 0) |
			(on << 5) | (sel << 4) | (pre << 2) | ve) :
			(a == 8'h01) ? ((au << 7) | (au && lk ? 64 : 0) |
			((au ? lk : tm) << 5)) : 0;
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		@(negedge sys_clk);
		ck("rd_data", e, 16'(rd_data));
		if (a == 8'h00) fl = 0;
	endtask

	// all register-driven outputs against the model
	task chk();
		@(negedge sys_clk);
		ck("prescale", pre, 16'(prescale_exp));
		ck("vco_exp", ve, 16'(vco_range_exponent));
		ck("mult", n == 0 ? 1 : n, 16'(feedback_multiplier));
		ck("range", lm, 16'(vco_centre_multiplier));
		ck("refdiv", rr == 0 ? 1 : rr, 16'(reference_division));
		ck("loop_en", on && lm != 0, 16'(loop_enable));
		ck("auto", au, 16'(self_tune_mode));
		ck("irq", au && ie && fl, 16'(clockgen_irq));
		ck("track", au ? lk : tm, 16'(filter_track_mode));
	endtask

	// lock toggle from the loop side
	task tog();
		@(posedge sys_clk);
		lock_req <= !lock_req;
		lk = !lk;
		fl = 1;
		repeat (10) @(posedge sys_clk);
	endtask

	// count base clock changes over 240 cycles, source period in ns
	task meas(input int per);
		int e;
		e = 960 / per;
		c = 0;
		b = base_clock_out;
		repeat (240) begin
			@(negedge sys_clk);
			if (base_clock_out !== b) c++;
			b = base_clock_out;
		end
		ck("base_toggles", e, 16'((c >= e - 2 && c <= e + 2) ? e : c));
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// hang guard
	initial begin
		repeat (50000) @(posedge sys_clk);
		bad_count++;
		wrap_up();
	end

	initial begin
		{reset_n, wr_en, rd_en, lock_req, addr, wr_data} = '0;
		{bad_count, n_checks, sel, pre, ve, ie, au, fl, tm, lk} = '0;
		{on, n, lm, rr, seed} = {32'd1, 32'h40, 32'h40, 32'd1, 32'd55522};
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		chk();
		rd(8'h00);
		rd(8'h01);
		rd(8'h06);
		for (i = 2; i < 6; i++) wr(8'(i), 8'($random(seed)));
		wr(8'h00, 8'h2F);
		chk();
		wr(8'h00, 8'h00);
		for (i = 0; i < 4; i++) begin
			wr(8'h00, 8'((i << 2) | (i % 3)));
			chk();
		end
		for (i = 2; i < 6; i++) wr(8'(i), 8'h00);
		chk();
		for (i = 2; i < 6; i++) wr(8'(i), 8'($random(seed)) | 8'h01);
		chk();
		wr(8'h00, 8'h10);
		wr(8'h00, 8'h30);
		rd(8'h00);
		wr(8'h00, 8'h00);
		wr(8'h04, 8'h00);
		wr(8'h00, 8'h20);
		wr(8'h00, 8'h30);
		rd(8'h00);
		chk();
		wr(8'h00, 8'h00);
		wr(8'h04, 8'h40);
		wr(8'h00, 8'h20);
		meas(40);
		wr(8'h00, 8'h30);
		repeat (2) @(negedge sys_clk);
		b = base_clock_out;
		c = 0;
		repeat (12) begin
			@(negedge sys_clk);
			if (base_clock_out !== b) c++;
		end
		ck("stasis", 0, 16'(c));
		repeat (40) @(posedge sys_clk);
		meas(24);
		wr(8'h00, 8'h10);
		rd(8'h00);
		wr(8'h00, 8'h20);
		wr(8'h00, 8'h00);
		tog();
		rd(8'h00);
		wr(8'h00, 8'hA0);
		rd(8'h00);
		wr(8'h01, 8'h20);
		rd(8'h01);
		chk();
		wr(8'h01, 8'hA0);
		rd(8'h01);
		wr(8'h00, 8'hA0);
		tog();
		chk();
		repeat (20) @(posedge sys_clk);
		chk();
		rd(8'h00);
		chk();
		tog();
		chk();
		wr(8'h00, 8'h20);
		chk();
		wrap_up();
	end
endmodule

bind pll_base_clock_control pll_base_clock_control_checker #(
	.EDGE_WAIT(EDGE_WAIT)) u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
	.addr(addr), .wr_en(wr_en), .rd_en(rd_en),
	.oscillator_clock(oscillator_clock),
	.divided_vco_clock(divided_vco_clock), .lock_detect(lock_detect),
	.loop_reference_clock(loop_reference_clock),
	.base_clock_out(base_clock_out), .clockgen_irq(clockgen_irq),
	.loop_enable(loop_enable), .prescale_exp(prescale_exp),
	.vco_range_exponent(vco_range_exponent),
	.feedback_multiplier(feedback_multiplier),
	.vco_centre_multiplier(vco_centre_multiplier),
	.reference_division(reference_division),
	.self_tune_mode(self_tune_mode));
